// >>> logic/rexc_pkg.sv
// Purpose: Constants and types for the reference and excitation config registers
// Assumes: APB slave, 32-bit data, byte addresses four times the register index
// Notes:   Field codes, register indices and the decoded analog bundle
// Function
// (RULE1) Monitor field decodes to monitor enables
// (RULE2) Bit 5 bypasses positive buffer
// (RULE3) Bit 4 bypasses negative buffer, resets set
// (RULE4) Source field selects converter reference
// (RULE5) Internal reference power policy decode
// (RULE6) Internal reference needs both buffers bypassed
// (RULE7) Power internal reference before excitation use
// (RULE8) Bit 7 enables output rail monitor
// (RULE9) Bit 6 closes switch, opens in power-down
// (RULE10) Bits 5:4 read zero, write zero
// (RULE11) Magnitude field drives both current sources
// (RULE12) Upper routing field steers source two
// (RULE13) Lower routing field steers source one
// (RULE14) Six-input variant remaps codes 6 and 7
// (RULE15) Level register index 06h, reset 00h
// (RULE16) Routing register index 07h, reset FFh
// (RULE17) Reference register index 05h, reset 10h
// (RULE18) Software avoids reserved encodings
// (RULE19) Fields stored, read back, drive outputs
`default_nettype none
package rexc_pkg;
    // ------------------------------------------------------------
    // Register map (indices; byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_VSOURCE    = 8'h05;
    localparam logic [7:0] IDX_LEVEL      = 8'h06;
    localparam logic [7:0] IDX_ROUTING    = 8'h07;
    localparam logic [7:0] RST_VSOURCE    = 8'h10;
    localparam logic [7:0] RST_LEVEL      = 8'h00;
    localparam logic [7:0] RST_ROUTING    = 8'hFF;
    localparam logic [7:0] LEVEL_WR_MASK  = 8'hCF;
    localparam int         ADDR_LSB       = 2;
    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [1:0] MON_OFF        = 2'h0;
    localparam logic [1:0] MON_LOW        = 2'h1;
    localparam logic [1:0] MON_LOW_THIRD  = 2'h2;
    localparam logic [1:0] MON_LOW_PULL   = 2'h3;
    localparam logic [1:0] IPWR_OFF       = 2'h0;
    localparam logic [1:0] IPWR_ON_PD_OFF = 2'h1;
    localparam logic [1:0] IPWR_ALWAYS    = 2'h2;
    localparam logic [3:0] ROUTE_REF_POS  = 4'h6;
    localparam logic [3:0] ROUTE_REF_NEG  = 4'h7;
    localparam logic [3:0] ROUTE_LAST_12  = 4'hB;
    localparam logic [3:0] ROUTE_LAST_6   = 4'h5;

    typedef struct packed {
        logic [1:0] vsource_monitor_cfg;
        logic       pos_buffer_bypass;
        logic       neg_buffer_bypass;
        logic [1:0] vsource_select;
        logic [1:0] internal_vsource_power;
    } rexc_vsource_type;

    typedef struct packed {
        logic       amp_output_monitor_on;
        logic       low_side_switch_close;
        logic [1:0] zero_bits;
        logic [3:0] excitation_magnitude;
    } rexc_level_type;

    typedef struct packed {
        logic [3:0] source2_route;
        logic [3:0] source1_route;
    } rexc_routing_type;

    // Decoded analog control lines
    typedef struct packed {
        logic       low_threshold_flag;
        logic       third_supply_flag;
        logic       pull_together_on;
        logic       pos_buffer_bypass;
        logic       neg_buffer_bypass;
        logic [1:0] vsource_select;
        logic       internal_vsource_on;
        logic       amp_output_monitor_on;
        logic       low_side_switch_close;
        logic [3:0] excitation_magnitude;
        logic       source1_routed;
        logic       source1_to_ref_pin;
        logic [3:0] source1_route;
        logic       source2_routed;
        logic       source2_to_ref_pin;
        logic [3:0] source2_route;
    } rexc_analog_type;
endpackage
`default_nettype wire

// >>> logic/rexc_regs.sv
// Purpose: APB register bank for reference and excitation configuration
// Assumes: Single clock pclk, async active-low presetn, APB slave ready one cycle after reset
// Notes:   Control outputs are registered; power_down comes from same-clock logic
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rexc_regs #(
    parameter bit SIX_INPUT = 1'b0                    // Six-input variant
) (
    input  wire logic                  pclk,          // Bus clock
    input  wire logic                  presetn,       // Async reset, low
    input  wire logic                  psel,          // APB select
    input  wire logic                  penable,       // APB access phase
    input  wire logic                  pwrite,        // APB direction
    input  wire logic [11:0]           paddr,         // APB byte address
    input  wire logic [31:0]           pwdata,        // APB write data
    input  wire logic [3:0]            pstrb,         // APB byte strobes
    output logic                       pready,        // APB ready
    output logic [31:0]                prdata,        // APB read data
    output logic                       pslverr,       // APB error
    input  wire logic                  power_down,    // Device power-down mode
    output rexc_pkg::rexc_analog_type  analog_ctrl    // Analog control lines
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rexc_pkg::rexc_vsource_type vsource;
        rexc_pkg::rexc_level_type   level;
        rexc_pkg::rexc_routing_type routing;
        logic [31:0]                rdata;
        logic                       err;
        logic                       ready;
        rexc_pkg::rexc_analog_type  ana;
    } rexc_state_type;

    rexc_state_type state;
    rexc_state_type next_state;

    logic [9:0] index;
    logic       setup;
    logic       access;
    logic       wr_ok;
    logic       mapped;

    // Full index width, so upper address bits do not alias onto the map
    assign index  = paddr[11:rexc_pkg::ADDR_LSB];
    assign setup  = psel & ~penable;
    assign access = psel & penable & state.ready;
    assign wr_ok  = pstrb[0];
    assign mapped = (index == 10'(rexc_pkg::IDX_VSOURCE))
                 || (index == 10'(rexc_pkg::IDX_LEVEL))
                 || (index == 10'(rexc_pkg::IDX_ROUTING));

    function automatic logic route_valid(input logic [3:0] code);
        route_valid = SIX_INPUT ? (code <= rexc_pkg::ROUTE_REF_NEG) : (code <= rexc_pkg::ROUTE_LAST_12);
    endfunction

    function automatic logic route_ref(input logic [3:0] code);
        route_ref = SIX_INPUT && (code == rexc_pkg::ROUTE_REF_POS || code == rexc_pkg::ROUTE_REF_NEG);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_state.ready = 1'b1;
        next_state.err   = 1'b0;
        // Loaded in setup, so read data and error stand at the access edge
        if (setup) begin
            next_state.err = !mapped;
            if (!pwrite) begin
                case (index)
                    10'(rexc_pkg::IDX_VSOURCE): next_state.rdata = {24'h000000, state.vsource}; // RULE19
                    10'(rexc_pkg::IDX_LEVEL):   next_state.rdata = {24'h000000, state.level}; // RULE10
                    10'(rexc_pkg::IDX_ROUTING): next_state.rdata = {24'h000000, state.routing}; // RULE19
                    default:                    next_state.rdata = 32'h00000000;
                endcase
            end
        end
        // Writes land on the access edge; unmapped or byte-0-masked ones are dropped
        if (access && pwrite && wr_ok) begin
            case (index)
                10'(rexc_pkg::IDX_VSOURCE): begin
                    next_state.vsource = pwdata[7:0]; // RULE19
                end
                10'(rexc_pkg::IDX_LEVEL): begin
                    next_state.level = pwdata[7:0] & rexc_pkg::LEVEL_WR_MASK; // RULE10
                end
                10'(rexc_pkg::IDX_ROUTING): begin
                    next_state.routing = pwdata[7:0]; // RULE19
                end
                default: begin
                end
            endcase
        end
        // Decode from the values about to be held
        next_state.ana.low_threshold_flag    = next_state.vsource.vsource_monitor_cfg != rexc_pkg::MON_OFF; // RULE1
        next_state.ana.third_supply_flag     = next_state.vsource.vsource_monitor_cfg == rexc_pkg::MON_LOW_THIRD; // RULE1
        next_state.ana.pull_together_on      = next_state.vsource.vsource_monitor_cfg == rexc_pkg::MON_LOW_PULL; // RULE1
        next_state.ana.pos_buffer_bypass     = next_state.vsource.pos_buffer_bypass; // RULE2
        next_state.ana.neg_buffer_bypass     = next_state.vsource.neg_buffer_bypass; // RULE3
        next_state.ana.vsource_select        = next_state.vsource.vsource_select; // RULE4
        // Policy 01 drops the reference in power-down, 10 keeps it
        next_state.ana.internal_vsource_on   = (next_state.vsource.internal_vsource_power == rexc_pkg::IPWR_ALWAYS)
            || (next_state.vsource.internal_vsource_power == rexc_pkg::IPWR_ON_PD_OFF && !power_down); // RULE5
        next_state.ana.amp_output_monitor_on = next_state.level.amp_output_monitor_on; // RULE8
        next_state.ana.low_side_switch_close = next_state.level.low_side_switch_close && !power_down; // RULE9
        next_state.ana.excitation_magnitude  = next_state.level.excitation_magnitude; // RULE11
        next_state.ana.source2_route         = next_state.routing.source2_route; // RULE12
        next_state.ana.source2_routed        = route_valid(next_state.routing.source2_route); // RULE12
        next_state.ana.source2_to_ref_pin    = route_ref(next_state.routing.source2_route); // RULE14
        next_state.ana.source1_route         = next_state.routing.source1_route; // RULE13
        next_state.ana.source1_routed        = route_valid(next_state.routing.source1_route); // RULE13
        next_state.ana.source1_to_ref_pin    = route_ref(next_state.routing.source1_route); // RULE14
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.vsource <= rexc_pkg::RST_VSOURCE; // RULE17
            state.level   <= rexc_pkg::RST_LEVEL; // RULE15
            state.routing <= rexc_pkg::RST_ROUTING; // RULE16
            state.rdata   <= 32'h00000000;
            state.err     <= 1'b0;
            state.ready   <= 1'b0;
            state.ana     <= '0;
            state.ana.neg_buffer_bypass <= rexc_pkg::RST_VSOURCE[4];
            state.ana.source1_route     <= rexc_pkg::RST_ROUTING[3:0];
            state.ana.source2_route     <= rexc_pkg::RST_ROUTING[7:4];
        end else begin
            state <= next_state;
        end
    end

    assign pready      = state.ready;
    assign prdata      = state.rdata;
    assign pslverr     = state.err;
    assign analog_ctrl = state.ana;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_LEVEL_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        state.level.zero_bits == 2'h0) else $error("reserved level bits not zero");
    AST_READ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        setup && !pwrite && index == 10'(rexc_pkg::IDX_LEVEL) |=> prdata[5:4] == 2'h0)
        else $error("reserved level bits read back set");
    AST_SWITCH_PD: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        $past(power_down) |-> !analog_ctrl.low_side_switch_close) else $error("switch closed in power-down");
    AST_THIRD: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        analog_ctrl.third_supply_flag |-> analog_ctrl.low_threshold_flag) else $error("third monitor alone");
    AST_POSBUF: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        analog_ctrl.pos_buffer_bypass == state.vsource[5]) else $error("pos bypass mismatch");
    AST_NEGBUF: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        analog_ctrl.neg_buffer_bypass == state.vsource[4]) else $error("neg bypass mismatch");
    AST_SEL: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        analog_ctrl.vsource_select == state.vsource[3:2]) else $error("source select mismatch");
    AST_IPWR_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        state.vsource[1:0] == rexc_pkg::IPWR_OFF |-> !analog_ctrl.internal_vsource_on) else $error("ref on");
    AST_MON: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        analog_ctrl.amp_output_monitor_on == state.level[7]) else $error("rail monitor mismatch");
    AST_MAG: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        analog_ctrl.excitation_magnitude == state.level[3:0]) else $error("magnitude mismatch");
    AST_ROUTE_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        state.routing[7:4] == 4'hF |-> !analog_ctrl.source2_routed) else $error("source2 routed at F");
    AST_ROUTE2: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        analog_ctrl.source2_route == state.routing[7:4]) else $error("source2 route mismatch");
    AST_ROUTE1: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        analog_ctrl.source1_route == state.routing[3:0]) else $error("source1 route mismatch");
    AST_REF_PIN: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        analog_ctrl.source1_to_ref_pin |-> SIX_INPUT && analog_ctrl.source1_routed)
        else $error("reference pin routing outside six-input build");
    AST_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
        access && pwrite && wr_ok && index == 10'(rexc_pkg::IDX_ROUTING)
        |=> state.routing == $past(pwdata[7:0])) else $error("routing write lost");
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the reference and excitation register bank
// Assumes: APB slave; read data and error are taken at the edge that sees pready high
// Notes:   Random legal field values from a fixed seed plus hand-picked corner writes
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, power_down = 1'b0, err;
    rexc_pkg::rexc_analog_type analog_ctrl;
    int          n_errors = 0, n_checks = 0, cycles = 0, seed = 32'h7c8927a2;
    logic [7:0]  sh [3];
    logic [31:0] d;
    rexc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .power_down(power_down), .analog_ctrl(analog_ctrl));
    // Six-input build on the same bus, so the pin remap is exercised too
    rexc_pkg::rexc_analog_type analog6;
    rexc_regs #(.SIX_INPUT(1'b1)) dut6 (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(),
        .prdata(),
        .pslverr(),
        .power_down(power_down),
        .analog_ctrl(analog6)
    );
    initial forever #5 pclk = ~pclk;
    // ----------------------------------------
    // Checks and bus cycles
    // ----------------------------------------
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin n_errors++; $display("[FAIL] %0t data %h exp %h", $time, got, exp); end
    endtask
    function automatic rexc_pkg::rexc_analog_type exp_a(input logic [7:0] r, l, m, input logic pd, six);
        rexc_pkg::rexc_analog_type e;
        e.low_threshold_flag = r[7:6] != 2'h0;
        e.third_supply_flag = r[7:6] == 2'h2;
        e.pull_together_on = r[7:6] == 2'h3;
        e.pos_buffer_bypass = r[5];
        e.neg_buffer_bypass = r[4];
        e.vsource_select = r[3:2];
        e.internal_vsource_on = (r[1:0] == 2'h2) || (r[1:0] == 2'h1 && !pd);
        e.amp_output_monitor_on = l[7];
        e.low_side_switch_close = l[6] && !pd; // Switch forced open in power-down
        e.excitation_magnitude = l[3:0];
        e.source1_routed = m[3:0] <= (six ? 4'h7 : 4'hB);
        e.source1_to_ref_pin = six && (m[3:0] == 4'h6 || m[3:0] == 4'h7); // Remap only on six inputs
        e.source1_route = m[3:0];
        e.source2_routed = m[7:4] <= (six ? 4'h7 : 4'hB);
        e.source2_to_ref_pin = six && (m[7:4] == 4'h6 || m[7:4] == 4'h7);
        e.source2_route = m[7:4];
        return e;
    endfunction
    task automatic chk_an;
        rexc_pkg::rexc_analog_type e12;
        rexc_pkg::rexc_analog_type e6;
        repeat (2) @(posedge pclk);
        #1;
        e12 = exp_a(sh[0], sh[1], sh[2], power_down, 1'b0);
        e6  = exp_a(sh[0], sh[1], sh[2], power_down, 1'b1);
        n_checks += 2;
        if (analog_ctrl !== e12) begin
            n_errors++;
            $display("[FAIL] %0t analog %h exp %h", $time, analog_ctrl, e12);
        end
        if (analog6 !== e6) begin
            n_errors++;
            $display("[FAIL] %0t six-input analog %h exp %h", $time, analog6, e6);
        end
    endtask
    // Holds the request until pready is seen high; only the timeout ends a wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_rd(input int i, input logic [7:0] v, input logic [7:0] exp);
        apb(1'b1, 12'h014 + 12'(4 * i), {24'h0, v}, 4'hF);
        apb(1'b0, 12'h014 + 12'(4 * i), 32'h0, 4'hF);
        sh[i] = exp;
        chk32(rd, {24'h0, exp});
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin n_errors++; $display("[FAIL] %0t timeout", $time); results(); end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        sh = '{8'h10, 8'h00, 8'hFF};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'h014 + 12'(4 * i), 32'h0, 4'hF);
            chk32(rd, {24'h0, sh[i]});
        end
        chk_an();
        $display("test reset done");
        wr_rd(0, 8'h16, 8'h16);
        wr_rd(1, 8'hF8, 8'hC8);
        wr_rd(2, 8'hBC, 8'hBC);
        chk_an();
        apb(1'b1, 12'h018, 32'h0000_0005, 4'hE);
        apb(1'b0, 12'h018, 32'h0, 4'hF);
        chk32(rd, {24'h0, sh[1]});
        apb(1'b0, 12'h020, 32'h0, 4'hF);
        chk32({31'h0, err}, 32'h1);
        $display("test corners done");
        for (int k = 0; k < 40; k++) begin
            d = $random(seed);
            if (d[3:2] == 2'h3) d[3:2] = 2'h2;
            if (d[1:0] == 2'h3) d[1:0] = 2'h1;
            if (d[3:2] == 2'h2) d[5:4] = 2'h3;
            wr_rd(0, d[7:0], d[7:0]);
            d = $random(seed);
            d[3:0] = 4'(d[3:0] % 9);
            d[5:4] = 2'h0;
            if (sh[0][1:0] == 2'h0) d[3:0] = 4'h0;
            wr_rd(1, d[7:0], d[7:0] & 8'hCF);
            d = $random(seed);
            wr_rd(2, d[7:0], d[7:0]);
            power_down <= d[8];
            chk_an();
        end
        $display("test random done");
        results();
    end
endmodule
`default_nettype wire
